// ### tcs_edge_sync.sv
// Purpose: two-flop synchroniser and edge detect for pins
// Assumes: pins are asynchronous to pclk
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module tcs_edge_sync
   import tcs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic [2:0] pin_in,
   tcs_if.sync sio
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
   } tcs_sync_t;
   tcs_sync_t st;
   tcs_sync_t next_st;

   // shift chain, s3 is the previous settled level
   always_comb
   begin
      next_st = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st <= '0;
      else if (clk_en)
         st <= next_st;
   end

   // ---------------------------------------------------------
   // edge outputs
   // ---------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < PIN_COUNT; i = i + 1)
      begin : g_edge
         assign sio.level[i] = st.s2[i];
         assign sio.fall[i] = st.s3[i] & ~st.s2[i];
         assign sio.rise[i] = st.s2[i] & ~st.s3[i];
      end
   endgenerate
endmodule
`default_nettype wire

// ### tcs_if.sv
// Purpose: carrier between the core, pin sync and prescaler
// Assumes: all signals on pclk
// Notes: fall and rise are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface tcs_if;
   // nets, so the per-bit generate assigns may share one vector
   wire [2:0] level;
   wire [2:0] fall;
   wire [2:0] rise;
   logic [1:0] prescale_sel;
   logic div12_tick;
   logic ext8_tick;
   logic shared_tick;
   modport sync (output level, output fall, output rise);
   modport pre (input rise, input prescale_sel, output div12_tick,
      output ext8_tick, output shared_tick);
   modport core (input level, input fall, input div12_tick,
      input ext8_tick, input shared_tick, output prescale_sel);
endinterface
`default_nettype wire

// ### tcs_pkg.sv
// Purpose: shared constants for the timer clock select block
// Assumes: 32-bit APB, one register per aligned word
// Notes: register index times four gives the byte address
//
// Notes on behaviour
// - bit 7 picks sysclk for timer 3 high
// - bit 6 picks sysclk for timer 3 low
// - bit 5 picks sysclk for timer 2 high
// - bit 4 picks sysclk for timer 2 low
// - bit 3: timer 1 sysclk, else prescaled
// - timer 1 counter mode overrides bit 3
// - bit 2: timer 0 sysclk, else prescaled
// - timer 0 counter mode overrides bit 2
// - prescale 00 divides 12, 01 divides 4
// - 10 divides 48, 11 synced ext/8
// - control register reachable on every page
// - timer 0 counts falling pin edges
package tcs_pkg;
   // ---------------------------------------------------------
   // register map
   // ---------------------------------------------------------
   localparam logic [9:0] CTRL_IDX = 10'h08E;
   localparam logic [9:0] AUX_IDX = 10'h08F;
   localparam logic [9:0] STAT_IDX = 10'h090;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] AUX_RST = 8'h00;
   // ---------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------
   localparam int TMR3_HIGH_SYSCLK_SEL = 7;
   localparam int TMR3_LOW_SYSCLK_SEL = 6;
   localparam int TMR2_HIGH_SYSCLK_SEL = 5;
   localparam int TMR2_LOW_SYSCLK_SEL = 4;
   localparam int TMR1_SYSCLK_SEL = 3;
   localparam int TMR0_SYSCLK_SEL = 2;
   localparam int SHARED_PRESCALE_LSB = 0;
   // ---------------------------------------------------------
   // auxiliary register fields
   // ---------------------------------------------------------
   localparam int TMR0_COUNTER_SELECT = 0;
   localparam int TMR1_COUNTER_SELECT = 1;
   localparam int TMR2_ALT_CLOCK_SEL = 2;
   localparam int TMR3_ALT_CLOCK_SEL = 3;
   localparam int TMR2_SPLIT = 4;
   localparam int TMR3_SPLIT = 5;
   localparam int AUX_BITS = 6;
   // ---------------------------------------------------------
   // synchronised pins and prescaler
   // ---------------------------------------------------------
   localparam int PIN_T0 = 0;
   localparam int PIN_T1 = 1;
   localparam int PIN_EXT = 2;
   localparam int PIN_COUNT = 3;
   localparam logic [1:0] PRE_DIV12 = 2'h0;
   localparam logic [1:0] PRE_DIV4 = 2'h1;
   localparam logic [1:0] PRE_DIV48 = 2'h2;
   localparam logic [1:0] PRE_EXT8 = 2'h3;
   localparam logic [3:0] DIV12_LAST = 4'hB;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   localparam logic [5:0] DIV48_LAST = 6'h2F;
   localparam logic [2:0] EXT8_LAST = 3'h7;
endpackage

// ### tcs_prescaler.sv
// Purpose: shared timer 0/1 prescaler and alternate clocks
// Assumes: ext clock rise pulses already synchronised
// Notes: all outputs are pclk count enables, not clocks
`timescale 1ns/1ps
`default_nettype none
module tcs_prescaler
   import tcs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   tcs_if.pre pio
);
   typedef struct packed {
      logic [3:0] c12;
      logic [1:0] c4;
      logic [5:0] c48;
      logic [2:0] ce;
      logic div12_tick;
      logic ext8_tick;
      logic shared_tick;
   } tcs_pre_t;
   tcs_pre_t st;
   tcs_pre_t next_st;
   logic d12;
   logic d4;
   logic d48;
   logic e8;

   // free-running dividers, ext/8 counts synced rises
   always_comb
   begin
      next_st = st;
      d12 = (st.c12 == DIV12_LAST);
      d4 = (st.c4 == DIV4_LAST);
      d48 = (st.c48 == DIV48_LAST);
      e8 = pio.rise[PIN_EXT] && (st.ce == EXT8_LAST);
      next_st.c12 = d12 ? 4'h0 : st.c12 + 4'h1;
      next_st.c4 = st.c4 + 2'h1;
      next_st.c48 = d48 ? 6'h00 : st.c48 + 6'h01;
      if (pio.rise[PIN_EXT])
         next_st.ce = st.ce + 3'h1;
      next_st.div12_tick = d12;
      next_st.ext8_tick = e8;
      // shared prescale mux
      case (pio.prescale_sel)
         PRE_DIV12: next_st.shared_tick = d12;
         PRE_DIV4: next_st.shared_tick = d4;
         PRE_DIV48: next_st.shared_tick = d48;
         PRE_EXT8: next_st.shared_tick = e8;
         default: next_st.shared_tick = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st <= '0;
      else if (clk_en)
         st <= next_st;
   end

   assign pio.div12_tick = st.div12_tick;
   assign pio.ext8_tick = st.ext8_tick;
   assign pio.shared_tick = st.shared_tick;

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   a_div12_wrap: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && st.c12 == 4'hB) |=> (st.div12_tick && st.c12 == 4'h0))
      else $error("div12 tick missing at wrap");
   a_div48_wrap: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && st.c48 == 6'h2F) |=> (st.c48 == 6'h00))
      else $error("div48 counter did not wrap at 47");
   a_ext8_tick: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && pio.rise[PIN_EXT] && st.ce == 3'h7) |=> st.ext8_tick)
      else $error("ext/8 tick missing on eighth rise");
   a_shared_div4: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && pio.prescale_sel == 2'h1)
      |=> (st.shared_tick == ($past(st.c4) == 2'h3)))
      else $error("prescaled tick not on div4 phase");
endmodule
`default_nettype wire

// ### tcs_top.sv
// Purpose: timer clock select with APB register access
// Assumes: APB3 master, pclk 125 MHz, pins async to pclk
// Notes: each tick output is a count enable for one cycle
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tcs_top
   import tcs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tmr0_pin,
   input wire logic tmr1_pin,
   input wire logic ext_clk_pin,
   output logic tmr0_tick,
   output logic tmr1_tick,
   output logic tmr2_low_tick,
   output logic tmr2_high_tick,
   output logic tmr3_low_tick,
   output logic tmr3_high_tick
);
   typedef struct packed {
      logic [7:0] timer_clock_control;
      logic [AUX_BITS-1:0] aux;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic t0;
      logic t1;
      logic t2l;
      logic t2h;
      logic t3l;
      logic t3h;
   } tcs_state_t;
   tcs_state_t st;
   tcs_state_t next_st;
   tcs_if bus ();
   logic alt2;
   logic alt3;
   logic ct0;
   logic ct1;
   logic wr_take;

   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   // page-free decode: the address alone selects the word
   function automatic logic tcs_hit(input logic [11:0] a,
      input logic [9:0] idx);
      tcs_hit = (a == {idx, 2'b00});
   endfunction

   function automatic logic tcs_mapped(input logic [11:0] a);
      tcs_mapped = tcs_hit(a, CTRL_IDX) || tcs_hit(a, AUX_IDX)
         || tcs_hit(a, STAT_IDX);
   endfunction

   // ---------------------------------------------------------
   // submodules
   // ---------------------------------------------------------
   tcs_edge_sync u_sync (
      .pclk (pclk),
      .presetn (presetn),
      .clk_en (clk_en),
      .pin_in ({ext_clk_pin, tmr1_pin, tmr0_pin}),
      .sio (bus.sync)
   );

   tcs_prescaler u_pre (
      .pclk (pclk),
      .presetn (presetn),
      .clk_en (clk_en),
      .pio (bus.pre)
   );

   assign bus.prescale_sel =
      st.timer_clock_control[SHARED_PRESCALE_LSB +: 2];

   // ---------------------------------------------------------
   // selection terms
   // ---------------------------------------------------------
   // alternate clock: sysclk/12 or synced ext/8
   assign alt2 = st.aux[TMR2_ALT_CLOCK_SEL] ? bus.ext8_tick
      : bus.div12_tick;
   assign alt3 = st.aux[TMR3_ALT_CLOCK_SEL] ? bus.ext8_tick
      : bus.div12_tick;
   assign ct0 = st.aux[TMR0_COUNTER_SELECT];
   assign ct1 = st.aux[TMR1_COUNTER_SELECT];
   // write lands only at the edge that completes the access
   assign wr_take = psel && penable && st.ready && pwrite;

   // ---------------------------------------------------------
   // next state
   // ---------------------------------------------------------
   always_comb
   begin
      next_st = st;
      // apb: setup phase prepares the answer, access completes
      next_st.ready = psel && !penable;
      if (psel && !penable)
      begin
         next_st.slverr = !tcs_mapped(paddr);
         next_st.rdata = 32'h0000_0000;
         if (!pwrite && tcs_hit(paddr, CTRL_IDX))
            next_st.rdata[7:0] = st.timer_clock_control;
         else if (!pwrite && tcs_hit(paddr, AUX_IDX))
            next_st.rdata[AUX_BITS-1:0] = st.aux;
         else if (!pwrite && tcs_hit(paddr, STAT_IDX))
            next_st.rdata[PIN_COUNT-1:0] = bus.level;
      end
      else
      begin
         next_st.slverr = 1'b0;
      end
      // register writes, status word is read only
      if (wr_take && tcs_hit(paddr, CTRL_IDX))
         next_st.timer_clock_control = pwdata[7:0];
      if (wr_take && tcs_hit(paddr, AUX_IDX))
         next_st.aux = pwdata[AUX_BITS-1:0];
      // timer 0: counter mode wins over the clock select
      if (ct0)
         next_st.t0 = bus.fall[PIN_T0];
      else if (st.timer_clock_control[TMR0_SYSCLK_SEL])
         next_st.t0 = 1'b1;
      else
         next_st.t0 = bus.shared_tick;
      // timer 1: same precedence as timer 0
      if (ct1)
         next_st.t1 = bus.fall[PIN_T1];
      else if (st.timer_clock_control[TMR1_SYSCLK_SEL])
         next_st.t1 = 1'b1;
      else
         next_st.t1 = bus.shared_tick;
      // timer 2 low byte or whole 16-bit timer
      next_st.t2l = st.timer_clock_control[TMR2_LOW_SYSCLK_SEL]
         ? 1'b1 : alt2;
      // high byte follows the low byte unless split
      if (st.aux[TMR2_SPLIT])
         next_st.t2h = st.timer_clock_control[TMR2_HIGH_SYSCLK_SEL]
            ? 1'b1 : alt2;
      else
         next_st.t2h = next_st.t2l;
      // timer 3, same shape as timer 2
      next_st.t3l = st.timer_clock_control[TMR3_LOW_SYSCLK_SEL]
         ? 1'b1 : alt3;
      if (st.aux[TMR3_SPLIT])
         next_st.t3h = st.timer_clock_control[TMR3_HIGH_SYSCLK_SEL]
            ? 1'b1 : alt3;
      else
         next_st.t3h = next_st.t3l;
   end

   // ---------------------------------------------------------
   // state register
   // ---------------------------------------------------------
   // clk_en low freezes everything, ticks included
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= '0;
         st.timer_clock_control <= CTRL_RST;
         st.aux <= AUX_RST[AUX_BITS-1:0];
      end
      else if (clk_en)
         st <= next_st;
   end

   // outputs straight from flops
   assign prdata = st.rdata;
   assign pready = st.ready;
   assign pslverr = st.slverr;
   assign tmr0_tick = st.t0;
   assign tmr1_tick = st.t1;
   assign tmr2_low_tick = st.t2l;
   assign tmr2_high_tick = st.t2h;
   assign tmr3_low_tick = st.t3l;
   assign tmr3_high_tick = st.t3h;

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   a_t3_high_sysclk: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && st.aux[TMR3_SPLIT] && st.timer_clock_control[7])
      |=> tmr3_high_tick)
      else $error("timer 3 high not on sysclk");
   a_t3_low_alt: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !st.timer_clock_control[6])
      |=> (tmr3_low_tick == $past(alt3)))
      else $error("timer 3 low not on alternate clock");
   a_t2_high_alt: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && st.aux[TMR2_SPLIT] && !st.timer_clock_control[5])
      |=> (tmr2_high_tick == $past(alt2)))
      else $error("timer 2 high not on alternate clock");
   a_t2_low_sysclk: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && st.timer_clock_control[4]) |=> tmr2_low_tick)
      else $error("timer 2 low not on sysclk");
   a_t1_prescaled: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !ct1 && !st.timer_clock_control[3])
      |=> (tmr1_tick == $past(bus.shared_tick)))
      else $error("timer 1 not on prescaled clock");
   a_t1_counter_wins: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ct1 && !bus.fall[PIN_T1]) |=> !tmr1_tick)
      else $error("timer 1 ticked without pin edge");
   a_t0_sysclk: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !ct0 && st.timer_clock_control[2]) |=> tmr0_tick)
      else $error("timer 0 not on sysclk");
   a_t0_counter_wins: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ct0 && !bus.fall[PIN_T0]) |=> !tmr0_tick)
      else $error("timer 0 ticked without pin edge");
   a_t0_pin_edge: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ct0 && bus.fall[PIN_T0]) |=> tmr0_tick)
      else $error("timer 0 missed a falling pin edge");
   a_ctrl_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_take && paddr == 12'h238)
      |=> (st.timer_clock_control == $past(pwdata[7:0])))
      else $error("control register write lost");

   // opposite polarity of every select, and the unsplit case
   a_t1_sysclk: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !ct1 && st.timer_clock_control[3]) |=> tmr1_tick)
      else $error("timer 1 not on sysclk");
   a_t1_pin_edge: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ct1 && bus.fall[PIN_T1]) |=> tmr1_tick)
      else $error("timer 1 missed a falling pin edge");
   a_t0_prescaled: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !ct0 && !st.timer_clock_control[2])
      |=> (tmr0_tick == $past(bus.shared_tick)))
      else $error("timer 0 not on prescaled clock");
   a_t2_low_alt: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !st.timer_clock_control[4])
      |=> (tmr2_low_tick == $past(alt2)))
      else $error("timer 2 low not on alternate clock");
   a_t3_low_sysclk: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && st.timer_clock_control[6]) |=> tmr3_low_tick)
      else $error("timer 3 low not on sysclk");
   a_t2_high_sysclk: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && st.aux[TMR2_SPLIT] && st.timer_clock_control[5])
      |=> tmr2_high_tick)
      else $error("timer 2 high not on sysclk");
   a_t3_high_alt: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && st.aux[TMR3_SPLIT] && !st.timer_clock_control[7])
      |=> (tmr3_high_tick == $past(alt3)))
      else $error("timer 3 high not on alternate clock");
   a_t2_unsplit: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !st.aux[TMR2_SPLIT])
      |=> (tmr2_high_tick == tmr2_low_tick))
      else $error("timer 2 high differs from low while unsplit");
   a_t3_unsplit: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !st.aux[TMR3_SPLIT])
      |=> (tmr3_high_tick == tmr3_low_tick))
      else $error("timer 3 high differs from low while unsplit");

   // bus answer shape; a stuck pready would hang the master
   a_ready_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && pready && penable) |=> !pready)
      else $error("bus answer held past one cycle");
   a_unmapped_err: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && !penable && !tcs_mapped(paddr))
      |=> (pready && pslverr && prdata == 32'h0000_0000))
      else $error("unmapped address not refused");
   a_ctrl_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && !penable && !pwrite && paddr == 12'h238)
      |=> (prdata == {24'h00_0000, $past(st.timer_clock_control)}))
      else $error("control register read wrong");

   // clk_en low must hold every tick output and pready
   a_freeze_ticks: assert property (
      @(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable({tmr0_tick, tmr1_tick, tmr2_low_tick,
         tmr2_high_tick, tmr3_low_tick, tmr3_high_tick, pready}))
      else $error("outputs moved while clock enable low");
endmodule
`default_nettype wire

// ### test_timer_clock_select.sv
// Purpose: self-checking bench for the timer clock select block
// Assumes: APB master in this bench, pins driven on pclk edges
// Notes: shadow registers predict readbacks, divide table the timer 0/1 prescale gaps
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("mismatch at %0t: %s", $time, msg); \
      end \
   end
module test_timer_clock_select
   import tcs_pkg::*;
;
   // ---------------------------------------------------------
   // stimulus and observation signals
   // ---------------------------------------------------------
   localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
   localparam logic [11:0] AUX_ADDR = {AUX_IDX, 2'b00};
   localparam logic [11:0] STAT_ADDR = {STAT_IDX, 2'b00};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic tmr0_pin = 1'b1;
   logic tmr1_pin = 1'b1;
   logic ext_clk_pin = 1'b0;
   logic ext_run = 1'b0;
   int ext_cnt = 0;
   wire [5:0] ticks;
   int err_total = 0;
   int checks = 0;
   int seed = 32'hed9e;
   int ctrl_m = 0;
   int aux_m = 0;
   int div_tab [3] = '{12, 4, 48};
   int n;
   int k;
   logic [31:0] d;
   logic e;

   // clock at 125 MHz
   always #4 pclk = ~pclk;

   tcs_top i_tcs_top (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tmr0_pin(tmr0_pin), .tmr1_pin(tmr1_pin),
      .ext_clk_pin(ext_clk_pin), .tmr0_tick(ticks[0]),
      .tmr1_tick(ticks[1]), .tmr2_low_tick(ticks[2]),
      .tmr2_high_tick(ticks[3]), .tmr3_low_tick(ticks[4]),
      .tmr3_high_tick(ticks[5])
   );

   // external clock, period six pclk cycles, only when asked for
   always @(posedge pclk)
   begin
      if (ext_run)
      begin
         ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
         if (ext_cnt == 2)
            ext_clk_pin <= ~ext_clk_pin;
      end
   end

   // ---------------------------------------------------------
   // bus and measurement tasks
   // ---------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd_d, output logic rd_e);
      int t;
      t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // bounded wait: no slave latency is assumed
      do
      begin
         @(posedge pclk);
         t++;
      end
      while (pready !== 1'b1 && t < 20);
      `CHK(pready, 1'b1, "no bus answer")
      rd_d = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] rd_d;
      logic rd_e;
      apb(1'b1, a, v, rd_d, rd_e);
      `CHK(rd_e, 1'b0, "write refused")
      if (a == CTRL_ADDR)
         ctrl_m = int'(v[7:0]);
      if (a == AUX_ADDR)
         aux_m = int'(v[5:0]);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x,
      input logic xe, input string msg);
      logic [31:0] rd_d;
      logic rd_e;
      apb(1'b0, a, 32'h0000_0000, rd_d, rd_e);
      `CHK(rd_d, x, msg)
      `CHK(rd_e, xe, msg)
   endtask

   // config, then let the selection settle for a few edges
   task automatic cfg(input logic [31:0] c, input logic [31:0] x);
      wr(CTRL_ADDR, c);
      wr(AUX_ADDR, x);
      repeat (3) @(posedge pclk);
   endtask

   // count the high cycles of one tick over a span
   task automatic cnt(input int t, input int span, output int hits);
      hits = 0;
      repeat (span)
      begin
         @(posedge pclk);
         if (ticks[t] === 1'b1)
            hits++;
         else if (ticks[t] !== 1'b0)
            hits += 100; // an unknown tick must spoil the count
      end
   endtask

   // cycles between two pulses; the first of two passes skips a stale one
   task automatic gap(input int t, output int g);
      int w;
      repeat (2)
      begin
         w = 0;
         g = 0;
         do
         begin
            @(posedge pclk);
            w++;
         end
         while (ticks[t] !== 1'b1 && w < 400);
         do
         begin
            @(posedge pclk);
            g++;
         end
         while (ticks[t] !== 1'b1 && g < 400);
      end
   endtask

   task conclude;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------
   // watchdog and main sequence
   // ---------------------------------------------------------
   initial
   begin
      repeat (60000) @(posedge pclk);
      err_total++;
      conclude();
   end

   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(CTRL_ADDR, 32'h0000_0000, 1'b0, "ctrl reset");
      rd(AUX_ADDR, 32'h0000_0000, 1'b0, "aux reset");
      // random values, upper bits must read back as zero
      repeat (4)
      begin
         d = $random(seed);
         wr(CTRL_ADDR, d);
         rd(CTRL_ADDR, ctrl_m, 1'b0, "ctrl readback");
         wr(AUX_ADDR, d);
         rd(AUX_ADDR, aux_m, 1'b0, "aux readback");
      end
      // unmapped place refused, read-only status ignores writes
      apb(1'b1, 12'h244, 32'hFFFF_FFFF, d, e);
      `CHK(e, 1'b1, "unmapped write")
      rd(12'h244, 32'h0000_0000, 1'b1, "unmapped read");
      rd(CTRL_ADDR, ctrl_m, 1'b0, "ctrl after bad write");
      wr(STAT_ADDR, 32'hFFFF_FFFF);
      rd(STAT_ADDR, 32'h0000_0003, 1'b0, "status pins");
      // each select bit gives a tick in every cycle
      for (k = 0; k < 6; k++)
      begin
         cfg(32'h1 << (k + 2), 32'h0000_0030);
         cnt(k, 8, n);
         `CHK(n, 8, "sysclk select")
      end
      // timer 0 and 1 prescaled paths, every internal divide
      for (k = 0; k < 3; k++)
      begin
         cfg(k, 32'h0000_0000);
         gap(0, n);
         `CHK(n, div_tab[k], "tmr0 prescale")
         gap(1, n);
         `CHK(n, div_tab[k], "tmr1 prescale")
      end
      // a frozen clock enable delays the next tick by the frozen span
      clk_en <= 1'b0;
      repeat (20) @(posedge pclk);
      clk_en <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (ticks[0] !== 1'b1 && k < 100);
      `CHK(k, div_tab[2], "tick held while frozen")
      // high byte selects do nothing without split mode
      cfg(32'h0000_00A0, 32'h0000_0000);
      gap(3, n);
      `CHK(n, 12, "tmr2 high unsplit")
      gap(5, n);
      `CHK(n, 12, "tmr3 high unsplit")
      cfg(32'h0000_00A0, 32'h0000_0030);
      gap(2, n);
      `CHK(n, 12, "tmr2 low alternate")
      gap(4, n);
      `CHK(n, 12, "tmr3 low alternate")
      // external clock through the prescaler and the alternate path
      ext_run <= 1'b1;
      cfg(32'h0000_0003, 32'h0000_000C);
      gap(0, n);
      `CHK(n, 48, "ext over eight")
      gap(2, n);
      `CHK(n, 48, "tmr2 alt ext")
      gap(4, n);
      `CHK(n, 48, "tmr3 alt ext")
      ext_run <= 1'b0;
      // counter mode beats the sysclk select bits
      cfg(32'h0000_000C, 32'h0000_0003);
      cnt(0, 20, n);
      `CHK(n, 0, "tmr0 counter idle")
      cnt(1, 20, n);
      `CHK(n, 0, "tmr1 counter idle")
      tmr0_pin <= 1'b0;
      cnt(0, 12, n);
      `CHK(n, 1, "tmr0 falling edge")
      tmr0_pin <= 1'b1;
      cnt(0, 12, n);
      `CHK(n, 0, "tmr0 rising edge")
      tmr1_pin <= 1'b0;
      cnt(1, 12, n);
      `CHK(n, 1, "tmr1 falling edge")
      conclude();
   end
endmodule
`default_nettype wire
